// ---- core/atc_pkg.sv ----
// Package for the angle tooth tick counter
// Behaviour
// - Tick period from top 15 rate bits
// - Overdue tick with missing count positive: nothing
// - Early tooth, missing count positive: high-rate
// - Missing count clears only then; final marker also at final tooth
// - Newly written missing count always honoured
// - Count decrements per microcycle in normal mode only; halt at zero
// - Normal entered from high-rate or halt
// - Insert request acts as a real tooth
// - Final tooth clears marker, insert, time base
// - New ticks apply at halt tooth, base zeroed if written in normal
`default_nettype none
package atc_pkg;
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;
  localparam int          TICKS_W     = 10;
  localparam int          MISS_W      = 2;
  localparam int          RATE_W      = 24;
  localparam int          RATE_INT_W  = 15;
  localparam int          RATE_INT_LSB = RATE_W - RATE_INT_W;
  localparam int          PRESC_W     = 6;
  localparam int          TB_W        = 24;
  // Register offsets
  localparam logic [7:0]  OFS_TOOTH   = 8'h00;
  localparam logic [7:0]  OFS_RATE    = 8'h04;
  localparam logic [7:0]  OFS_TBCFG   = 8'h08;
  localparam logic [7:0]  OFS_STATUS  = 8'h0C;
  localparam logic [7:0]  OFS_TBASE   = 8'h10;
  // Tooth program fields
  localparam int          TICKS_LSB   = 0;
  localparam int          LAST_BIT    = 10;
  localparam int          INSERT_BIT  = 11;
  localparam int          MISS_LSB    = 12;
  // Reset values
  localparam logic [TICKS_W-1:0] TICKS_RST = 10'h000;
  localparam logic [RATE_W-1:0]  RATE_RST  = 24'h000200;
  localparam logic [PRESC_W-1:0] PRESC_RST = 6'h00;
  typedef enum logic [1:0] {
    MODE_HALT   = 2'b00,
    MODE_NORMAL = 2'b01,
    MODE_HIGH   = 2'b10
  } atc_mode_t;
endpackage : atc_pkg
`default_nettype wire

// ---- core/atc_div_if.sv ----
// Interface between the counter core and a rate divider
`timescale 1ns/1ps
`default_nettype none
interface atc_div_if #(parameter int W = 8);
  logic         run;
  logic         restart;
  logic [W-1:0] period;
  logic         strobe;
  modport ctl (output run, output restart, output period, input strobe);
  modport div (input run, input restart, input period, output strobe);
endinterface : atc_div_if
`default_nettype wire

// ---- core/atc_div.sv ----
// Divider: one strobe every period counted run cycles
`timescale 1ns/1ps
`default_nettype none
module atc_div #(
  parameter int W = 8
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  atc_div_if.div    bus
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  wire          last_w = (cnt_reg + W'(1) >= bus.period);
  assign bus.strobe = bus.run & last_w;
  assign cnt_next   = bus.restart ? '0 :
                      (bus.run ? (last_w ? '0 : cnt_reg + W'(1)) : cnt_reg);
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= '0;
    end else if (i_ce) begin
      cnt_reg <= cnt_next;
    end
  end
endmodule // atc_div
`default_nettype wire

// ---- core/atc_top.sv ----
// Angle tooth tick counter with APB register port
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module atc_top (
  input  wire logic                       I_CLK_SYS,
  input  wire logic                       I_RESET_N,
  input  wire logic                       I_CE,
  input  wire logic                       I_PSEL,
  input  wire logic                       I_PENABLE,
  input  wire logic                       I_PWRITE,
  input  wire logic [atc_pkg::ADDR_W-1:0] I_PADDR,
  input  wire logic [atc_pkg::DATA_W-1:0] I_PWDATA,
  output var  logic [atc_pkg::DATA_W-1:0] O_PRDATA,
  output wire logic                       O_PREADY,
  output wire logic                       O_PSLVERR,
  input  wire logic                       I_TOOTH,
  output wire logic                       O_ANGLE_TICK,
  output wire logic [1:0]                 O_MODE,
  output wire logic [atc_pkg::TB_W-1:0]   O_ANGLE_TIMEBASE
);
  import atc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  atc_mode_t            mode_reg;
  atc_mode_t            mode_next;
  logic [TICKS_W-1:0]   ticks_prog_reg;
  logic [TICKS_W-1:0]   ticks_prog_next;
  logic [TICKS_W-1:0]   ticks_act_reg;
  logic [TICKS_W-1:0]   ticks_act_next;
  logic                 ticks_pend_reg;
  logic                 ticks_pend_next;
  logic [MISS_W-1:0]    miss_reg;
  logic [MISS_W-1:0]    miss_next;
  logic                 last_reg;
  logic                 last_next;
  logic                 insert_reg;
  logic                 insert_next;
  logic [RATE_W-1:0]    rate_reg;
  logic [RATE_W-1:0]    rate_next;
  logic [PRESC_W-1:0]   presc_reg;
  logic [PRESC_W-1:0]   presc_next;
  logic [TICKS_W-1:0]   tick_cnt_reg;
  logic [TICKS_W-1:0]   tick_cnt_next;
  logic [TB_W-1:0]      tb_reg;
  logic [TB_W-1:0]      tb_next;
  logic                 tooth_dly_reg;
  logic [DATA_W-1:0]    rdata_reg;
  logic [DATA_W-1:0]    rdata_next;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  wire setup_w   = I_PSEL & ~I_PENABLE;
  wire access_w  = I_PSEL & I_PENABLE;
  wire sel_tooth = (I_PADDR == OFS_TOOTH);
  wire sel_rate  = (I_PADDR == OFS_RATE);
  wire sel_tbcfg = (I_PADDR == OFS_TBCFG);
  wire sel_stat  = (I_PADDR == OFS_STATUS);
  wire sel_tbase = (I_PADDR == OFS_TBASE);
  wire mapped_w  = sel_tooth | sel_rate | sel_tbcfg | sel_stat | sel_tbase;
  wire wr_w      = access_w & I_PWRITE & I_CE;
  wire tpr_wr    = wr_w & sel_tooth;
  wire rate_wr   = wr_w & sel_rate;
  wire tbcfg_wr  = wr_w & sel_tbcfg;

  assign O_PREADY  = access_w;
  assign O_PSLVERR = access_w & ~mapped_w;

  wire [TICKS_W-1:0] wr_ticks  = I_PWDATA[TICKS_LSB +: TICKS_W];
  wire [MISS_W-1:0]  wr_miss   = I_PWDATA[MISS_LSB +: MISS_W];
  wire               wr_last   = I_PWDATA[LAST_BIT];
  wire               wr_insert = I_PWDATA[INSERT_BIT];

  wire [DATA_W-1:0] tooth_rd = DATA_W'({miss_reg, insert_reg, last_reg, ticks_prog_reg});
  wire [DATA_W-1:0] rd_mux   =
    sel_tooth ? tooth_rd :
    sel_rate  ? DATA_W'(rate_reg) :
    sel_tbcfg ? DATA_W'(presc_reg) :
    sel_stat  ? DATA_W'({ticks_pend_reg, mode_reg}) :
    sel_tbase ? DATA_W'(tb_reg) : '0;
  assign rdata_next = (setup_w & ~I_PWRITE) ? rd_mux : rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Microcycle and tick dividers
  atc_div_if #(.W(PRESC_W + 1))  micro_if ();
  atc_div_if #(.W(RATE_INT_W))   tick_if ();

  atc_div #(.W(PRESC_W + 1)) u_micro_div (
    .i_clk   (I_CLK_SYS),
    .i_rst_n (I_RESET_N),
    .i_ce    (I_CE),
    .bus     (micro_if.div)
  );

  atc_div #(.W(RATE_INT_W)) u_tick_div (
    .i_clk   (I_CLK_SYS),
    .i_rst_n (I_RESET_N),
    .i_ce    (I_CE),
    .bus     (tick_if.div)
  );

  wire micro_w = micro_if.strobe;
  assign micro_if.run     = 1'b1;
  assign micro_if.restart = 1'b0;
  assign micro_if.period  = (PRESC_W + 1)'(presc_reg) + (PRESC_W + 1)'(1);

  wire is_halt   = (mode_reg == MODE_HALT);
  wire is_normal = (mode_reg == MODE_NORMAL);
  wire is_high   = (mode_reg == MODE_HIGH);

  ////////////////////////////////////////////////////////////////////////////
  // Tooth events and tick timing
  wire tooth_phys = I_TOOTH & ~tooth_dly_reg;
  wire tooth_evt  = tooth_phys | insert_reg;

  assign tick_if.run     = micro_w & is_normal;
  assign tick_if.restart = tooth_evt;
  assign tick_if.period  = rate_reg[RATE_INT_LSB +: RATE_INT_W];

  wire tick_time  = (is_normal & tick_if.strobe) | (is_high & micro_w);
  wire tooth_due  = (tick_cnt_reg >= ticks_act_reg);
  wire angle_tick = tick_time & ~tooth_due;
  wire miss_pos   = (miss_reg != '0);
  wire early_w    = tooth_evt & ~tooth_due;
  wire to_high    = is_normal & early_w & miss_pos;
  wire final_w    = is_normal & tooth_evt & last_reg & ~to_high;
  wire halt_load  = is_halt & tooth_evt;
  wire tb_clr     = final_w | (halt_load & ticks_pend_reg);

  assign O_ANGLE_TICK     = angle_tick;
  assign O_MODE           = mode_reg;
  assign O_ANGLE_TIMEBASE = tb_reg;
  assign O_PRDATA         = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Mode sequencing
  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      MODE_HALT: begin
        if (tooth_evt) begin
          mode_next = MODE_NORMAL;
        end
      end
      MODE_NORMAL: begin
        if (to_high) begin
          mode_next = MODE_HIGH;
        end else if (tooth_evt) begin
          mode_next = MODE_NORMAL;
        end else if (tick_time & tooth_due & ~miss_pos) begin
          mode_next = MODE_HALT;
        end
      end
      MODE_HIGH: begin
        if (tick_time & tooth_due & ~tooth_evt) begin
          mode_next = MODE_NORMAL;
        end
      end
      default: mode_next = MODE_HALT;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field updates
  assign miss_next = tpr_wr ? wr_miss :
                     to_high ? '0 :
                     (is_normal & micro_w & miss_pos) ? miss_reg - MISS_W'(1) :
                     miss_reg;
  assign last_next = tpr_wr ? wr_last :
                     (to_high | final_w) ? 1'b0 :
                     last_reg;
  assign insert_next = (tpr_wr & wr_insert) ? 1'b1 :
                       (insert_reg | final_w) ? 1'b0 :
                       insert_reg;
  assign ticks_prog_next = tpr_wr ? wr_ticks : ticks_prog_reg;
  assign ticks_pend_next = (tpr_wr & is_normal) ? 1'b1 :
                           halt_load ? 1'b0 : ticks_pend_reg;
  assign ticks_act_next  = halt_load ? ticks_prog_reg : ticks_act_reg;
  assign tick_cnt_next   = tooth_evt ? '0 :
                           angle_tick ? tick_cnt_reg + TICKS_W'(1) : tick_cnt_reg;
  assign tb_next = tb_clr ? '0 :
                   angle_tick ? tb_reg + TB_W'(1) : tb_reg;
  assign rate_next  = rate_wr ? I_PWDATA[RATE_W-1:0] : rate_reg;
  assign presc_next = tbcfg_wr ? I_PWDATA[PRESC_W-1:0] : presc_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      mode_reg       <= MODE_HALT;
      miss_reg       <= '0;
      last_reg       <= 1'b0;
      insert_reg     <= 1'b0;
      ticks_prog_reg <= TICKS_RST;
      ticks_act_reg  <= TICKS_RST;
      ticks_pend_reg <= 1'b0;
      tick_cnt_reg   <= '0;
      tooth_dly_reg  <= 1'b0;
    end else if (I_CE) begin
      mode_reg       <= mode_next;
      miss_reg       <= miss_next;
      last_reg       <= last_next;
      insert_reg     <= insert_next;
      ticks_prog_reg <= ticks_prog_next;
      ticks_act_reg  <= ticks_act_next;
      ticks_pend_reg <= ticks_pend_next;
      tick_cnt_reg   <= tick_cnt_next;
      tooth_dly_reg  <= I_TOOTH;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      tb_reg    <= '0;
      rate_reg  <= RATE_RST;
      presc_reg <= PRESC_RST;
      rdata_reg <= '0;
    end else if (I_CE) begin
      tb_reg    <= tb_next;
      rate_reg  <= rate_next;
      presc_reg <= presc_next;
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RESET_N);

  tick_period_a: assert property (
    tick_if.period == rate_reg[23:9])
    else $error("tick divider period not taken from rate integer");

  overdue_hold_a: assert property (
    I_CE && is_normal && tick_time && !tooth_evt && miss_pos |=> is_normal)
    else $error("left normal mode with missing count positive");

  early_high_a: assert property (
    I_CE && is_normal && early_w && miss_pos |=> is_high)
    else $error("early tooth did not switch to high-rate");

  miss_clear_a: assert property (
    I_CE && !tpr_wr && is_normal && miss_pos && !micro_w
      |=> (miss_reg == 2'h0) == (mode_reg == MODE_HIGH))
    else $error("missing count cleared without high-rate switch");

  miss_write_a: assert property (
    tpr_wr |=> miss_reg == $past(wr_miss))
    else $error("written missing count not honoured");

  halt_zero_a: assert property (
    is_normal ##1 is_halt |-> $past(miss_reg) == 2'h0)
    else $error("halt entered with missing count positive");

  insert_tooth_a: assert property (
    I_CE && is_halt && insert_reg && !tpr_wr |=> is_normal && !insert_reg)
    else $error("insert request not treated as tooth");

  final_tooth_a: assert property (
    I_CE && final_w && !tpr_wr |=> is_normal && !last_reg && tb_reg == 24'h000000)
    else $error("final tooth handling wrong");

  ticks_apply_a: assert property (
    I_CE && halt_load |=> ticks_act_reg == $past(ticks_prog_reg))
    else $error("ticks value not applied at halt tooth");

  tb_count_a: assert property (
    I_CE && angle_tick && !tb_clr |=> tb_reg == $past(tb_reg) + 24'h000001)
    else $error("time base did not advance on angle tick");

  tb_halt_a: assert property (
    I_CE && is_halt && !tooth_evt |=> tb_reg == $past(tb_reg))
    else $error("time base moved in halt mode");

  halt_wake_a: assert property (
    I_CE && is_halt && tooth_evt |=> is_normal)
    else $error("tooth in halt did not enter normal mode");

  miss_step_a: assert property (
    I_CE && !tpr_wr && !to_high && is_normal && micro_w && miss_pos
      |=> miss_reg == $past(miss_reg) - 2'h1)
    else $error("missing count did not step per microcycle");

  to_high_c: cover property (is_normal ##1 is_high);
  to_normal_c: cover property (is_high ##1 is_normal);
  to_halt_c: cover property (is_normal ##1 is_halt);
  final_c: cover property (I_CE && final_w);
  overdue_c: cover property (I_CE && is_normal && tick_time && tooth_due && miss_pos);

endmodule // atc_top
`default_nettype wire

// ---- sim/atc_wheel.sv ----
// Tooth wheel model: one tooth pulse per request
`timescale 1ns/1ps
`default_nettype none
module atc_wheel (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_fire,
  output wire logic o_tooth
);
  logic [1:0] hold_reg;
  ////////////////////////////////////////////////////////////////
  // Tooth high two cycles, then low until the next request
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hold_reg <= 2'h0;
    end else if (i_fire) begin
      hold_reg <= 2'h2;
    end else if (hold_reg != 2'h0) begin
      hold_reg <= hold_reg - 2'h1;
    end
  end
  assign o_tooth = (hold_reg != 2'h0);
endmodule // atc_wheel
`default_nettype wire

// ---- sim/atc_top_tb.sv ----
// Testbench for the angle tooth tick counter
`timescale 1ns/1ps
`default_nettype none
module atc_top_tb;
  import atc_pkg::*;
  logic        clk, rst_n, ce, psel, penable, pwrite, fire, tooth, tick, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0]  mode;
  logic [23:0] tbase;
  int          miscompares, n_checks;

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  atc_top dut (.I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_CE(ce), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_TOOTH(tooth),
    .O_ANGLE_TICK(tick), .O_MODE(mode), .O_ANGLE_TIMEBASE(tbase));
  atc_wheel wheel (.i_clk(clk), .i_rst_n(rst_n), .i_fire(fire), .o_tooth(tooth));

  ////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("apb ready", 1'b1, pready);
    if (pready !== 1'b1) wrap_up();
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask

  task automatic kick();
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic wait_mode(input logic [1:0] m);
    int n = 0;
    while (mode !== m && n < 1000) begin
      @(posedge clk);
      n++;
    end
    chk("mode reached", m, mode);
    if (mode !== m) wrap_up();
  endtask

  task automatic run(input int ticks, input int gap, input logic [23:0] base);
    int n = 0;
    int cnt = 0;
    int last = -1;
    int sp = 0;
    while (mode === MODE_HALT && n < 8) begin
      @(posedge clk);
      n++;
    end
    chk("mode left halt", MODE_NORMAL, mode);
    n = 0;
    while (mode !== MODE_HALT && n < 2000) begin
      if (tick === 1'b1) begin
        sp = n - last;
        last = n;
        cnt++;
      end
      @(posedge clk);
      n++;
    end
    chk("halt reached", MODE_HALT, mode);
    chk("tick count", ticks, cnt);
    chk("tick spacing", gap, sp);
    chk("timebase at halt", base, tbase);
    repeat (12) @(posedge clk);
    chk("timebase holds", base, tbase);
  endtask

  ////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_regs();
    logic [31:0] q;
    logic        e;
    rd(OFS_RATE, q);
    chk("rate reset", 32'h00000200, q);
    rd(OFS_TOOTH, q);
    chk("tooth reset", 32'h0, q);
    wr(OFS_TBASE, 32'h00000055);
    rd(OFS_TBASE, q);
    chk("timebase read only", 32'h0, q);
    apb(1'b0, 8'h40, 32'h0, q, e);
    chk("unmapped error", 1'b1, e);
    chk("unmapped data", 32'h0, q);
    $display("test regs done");
  endtask

  task automatic t_ticks();
    wr(OFS_RATE, 32'h000009FF);
    wr(OFS_TBCFG, 32'h0);
    wr(OFS_TOOTH, 32'h00000003);
    kick();
    run(3, 4, 24'h000003);
    kick();
    wr(OFS_TOOTH, 32'h00000005);
    wait_mode(MODE_HALT);
    chk("old ticks kept", 24'h000006, tbase);
    kick();
    run(5, 4, 24'h000005);
    wr(OFS_TOOTH, 32'h00000805);
    run(5, 4, 24'h00000A);
    $display("test ticks done");
  endtask

  task automatic t_missing();
    logic [31:0] q;
    int          n = 0;
    wr(OFS_TBCFG, 32'h00000007);
    wr(OFS_TOOTH, 32'h00000004);
    kick();
    wr(OFS_TOOTH, 32'h00003004);
    rd(OFS_TOOTH, q);
    chk("new count honoured", 1'b1, q[13:12] >= 2'h2);
    while (q[13:12] !== 2'h0 && n < 20) begin
      chk("normal while counting", MODE_NORMAL, mode);
      rd(OFS_TOOTH, q);
      n++;
    end
    chk("count ran out", 2'h0, q[13:12]);
    wr(OFS_TOOTH, 32'h00003404);
    kick();
    chk("early tooth mode", MODE_HIGH, mode);
    rd(OFS_TOOTH, q);
    chk("count cleared", 2'h0, q[13:12]);
    chk("marker cleared", 1'b0, q[10]);
    wait_mode(MODE_NORMAL);
    wait_mode(MODE_HALT);
    $display("test missing done");
  endtask

  task automatic t_final();
    logic [31:0] q;
    wr(OFS_TBCFG, 32'h0);
    wr(OFS_TOOTH, 32'h00000008);
    kick();
    wr(OFS_TOOTH, 32'h00000C08);
    repeat (2) @(posedge clk);
    chk("timebase cleared", 24'h000000, tbase);
    chk("no halt", MODE_NORMAL, mode);
    ce <= 1'b0;
    repeat (12) @(posedge clk);
    chk("frozen timebase", 24'h000000, tbase);
    chk("frozen mode", MODE_NORMAL, mode);
    ce <= 1'b1;
    rd(OFS_TOOTH, q);
    chk("marker and insert", 2'h0, q[11:10]);
    wait_mode(MODE_HALT);
    $display("test final done");
  endtask

  task automatic t_overdue();
    logic [31:0] q;
    wr(OFS_RATE, 32'h00000400);
    wr(OFS_TBCFG, 32'h00000003);
    wr(OFS_TOOTH, 32'h00003000);
    rd(OFS_STATUS, q);
    chk("status pending", 32'h00000004, q);
    kick();
    repeat (8) @(posedge clk);
    chk("normal at overdue tick", MODE_NORMAL, mode);
    wait_mode(MODE_HALT);
    rd(OFS_TOOTH, q);
    chk("count zero at halt", 2'h0, q[13:12]);
    rd(OFS_STATUS, q);
    chk("status after halt tooth", 32'h00000000, q);
    $display("test overdue done");
  endtask

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fire = 1'b0;
    ce = 1'b1;
    miscompares = 0;
    n_checks = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_ticks();
    t_missing();
    t_final();
    t_overdue();
    wrap_up();
  end
endmodule // atc_top_tb
`default_nettype wire
